/* dacfg_chk.sv */
// Assertions on the register link and forwarded clock between the two ends.
// Assumes clk and reset are the bench's system clock and reset.
`timescale 1ns/1ps

module dacfg_chk (
    // Clocks and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic linkClk,
    // Link signals
    input wire logic sampleClk,
    input wire dacfg_pkg::dacfg_addr_t mcAddr,
    input wire logic mcWr,
    input wire logic mcRd,
    input wire dacfg_pkg::dacfg_byte_t mcRdData,
    input wire logic mcAck
);
    import dacfg_pkg::*;

    logic [3:0] linkRun;

    ////////////////////////////////////////
    // Link reset is synced late, so give the clock a few cycles to start
    always_ff @(posedge linkClk) begin
        if (reset) begin
            linkRun <= 4'h0;
        end else if (linkRun != 4'h8) begin
            linkRun <= linkRun + 4'h1;
        end
    end

    // Request kinds
    sequence strobe_s;
        mcWr || mcRd;
    endsequence
    sequence status_rd_s;
        mcRd && (mcAddr == ADDR_STATUS);
    endsequence
    sequence unmapped_rd_s;
        mcRd && (mcAddr > ADDR_STATUS);
    endsequence

    ////////////////////////////////////////
    // Register link strobes and answers
    ack_follows_a: assert property (@(posedge clk) disable iff (reset) strobe_s |=> mcAck)
        else $error("no answer after strobe");
    ack_cause_a: assert property (@(posedge clk) disable iff (reset) mcAck |-> $past(mcWr) || $past(mcRd))
        else $error("answer without strobe");
    wr_ack_zero_a: assert property (@(posedge clk) disable iff (reset) mcWr |=> mcRdData == 8'h00)
        else $error("write answer carries data");
    status_zero_a: assert property (@(posedge clk) disable iff (reset) status_rd_s |=> mcRdData[7:1] == 7'h00)
        else $error("status upper bits set");
    unmapped_zero_a: assert property (@(posedge clk) disable iff (reset) unmapped_rd_s |=> mcRdData == 8'h00)
        else $error("unmapped read not zero");
    strobe_gap_a: assert property (@(posedge clk) disable iff (reset) strobe_s |=> (!mcWr && !mcRd) [*2])
        else $error("strobes too close");
    strobe_excl_a: assert property (@(posedge clk) disable iff (reset) !(mcWr && mcRd))
        else $error("read and write together");
    // Forwarded clock keeps running once out of reset
    clk_toggle_a: assert property (@(posedge linkClk) disable iff (reset)
        (linkRun == 4'h8) |-> sampleClk != $past(sampleClk))
        else $error("forwarded clock stalled");

endmodule // dacfg_chk

/* dacfg_device.sv */
// Converter device end: register file on the system clock, sample forwarding on the
// converter clock. Assumes the converter core presents two's complement samples on linkClk,
// and that an outside clock source applies synthFreqHz on synthLoad.
`timescale 1ns/1ps

module dacfg_device (
    // System clock and reset
    input wire logic clk,
    input wire logic reset,
    // Converter clock, whichever source the jumper selected
    input wire logic linkClk,
    // Converter samples, linkClk domain
    input wire dacfg_pkg::dacfg_word_t iSample,
    input wire dacfg_pkg::dacfg_word_t qSample,
    // Synthesizer lock pin, asynchronous
    input wire logic synthLocked,
    // Stored configuration, read once after reset
    input wire dacfg_pkg::dacfg_nv_t nvImage,
    // Link to the receiving logic
    dacfg_link_if.device link,
    // Synthesizer control
    output dacfg_pkg::dacfg_freq_t synthFreqHz,
    output logic synthLoad,
    output logic synthEnable,
    output logic ddrMode,
    // Configuration image for the non-volatile store
    output dacfg_pkg::dacfg_nv_t nvImageOut
);
    import dacfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register state

    dacfg_byte_t freqByte [4];
    dacfg_byte_t modeReg;
    logic nvLoadPending;
    logic lockSync;

    // Converter-clock domain state
    logic linkReset;
    logic linkDdr;
    logic phase;
    dacfg_word_t evenI;
    dacfg_word_t evenQ;
    dacfg_word_t holdQa;
    dacfg_word_t holdQb;

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    // Only addresses 0..4 store; anything else is dropped
    wire freqWrite = link.mcWr && (link.mcAddr <= ADDR_FREQ3); // RQ13
    wire modeWrite = link.mcWr && (link.mcAddr == ADDR_MODE); // RQ9
    wire [1:0] byteSel = link.mcAddr[1:0];

    // Pending rate from the byte registers, LSB in byte 0
    wire dacfg_freq_t pendingFreq = {freqByte[3], freqByte[2], freqByte[1], freqByte[0]}; // RQ7

    // Stored image: mode byte on top, rate bytes below
    wire dacfg_freq_t nvFreq = nvImage[31:0];
    wire dacfg_byte_t nvMode = nvImage[39:32];

    // Status byte shows lock in bit 0, other bits zero
    wire dacfg_byte_t statusByte = {7'h00, lockSync}; // RQ15

    // Read mux; unmapped addresses read zero
    wire dacfg_byte_t readMux =
        (link.mcAddr <= ADDR_FREQ3) ? freqByte[byteSel] :
        (link.mcAddr == ADDR_MODE) ? modeReg :
        (link.mcAddr == ADDR_STATUS) ? statusByte : READ_ZERO; // RQ14

    ////////////////////////////////////////////////////////////////////////////
    // Lock pin into the system clock domain

    dacfg_sync #(.W(1)) lockSyncer (
        .clk(clk),
        .d(synthLocked),
        .q(lockSync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Control registers

    // Byte writes only stage; the rate reaches the synthesizer on a mode write
    always_ff @(posedge clk) begin
        if (reset) begin
            freqByte[0] <= RESET_FREQ0;
            freqByte[1] <= RESET_FREQ1;
            freqByte[2] <= RESET_FREQ2;
            freqByte[3] <= RESET_FREQ3;
            modeReg <= RESET_MODE;
            nvLoadPending <= 1'b1;
        end else if (nvLoadPending) begin
            // Restore the stored setup once, after release
            freqByte[0] <= nvFreq[7:0]; // RQ16
            freqByte[1] <= nvFreq[15:8];
            freqByte[2] <= nvFreq[23:16];
            freqByte[3] <= nvFreq[31:24];
            modeReg <= nvMode;
            nvLoadPending <= 1'b0;
        end else begin
            if (freqWrite) begin
                freqByte[byteSel] <= link.mcWrData; // RQ20
            end
            if (modeWrite) begin
                modeReg <= link.mcWrData; // RQ14
            end
        end
    end

    // Apply rate and mode to the synthesizer; a rewrite of the same value still reloads
    always_ff @(posedge clk) begin
        if (reset) begin
            synthFreqHz <= quantize({RESET_FREQ3, RESET_FREQ2, RESET_FREQ1, RESET_FREQ0}, 1'b0);
            synthEnable <= 1'b1;
            ddrMode <= 1'b0;
            synthLoad <= 1'b0;
        end else if (nvLoadPending) begin
            synthFreqHz <= quantize(nvFreq, nvMode[MODE_DDR_BIT]); // RQ8
            synthEnable <= nvMode[MODE_SYNTH_ON_BIT];
            ddrMode <= nvMode[MODE_DDR_BIT];
            synthLoad <= 1'b1;
        end else begin
            synthLoad <= modeWrite; // RQ9
            if (modeWrite) begin
                synthFreqHz <= quantize(pendingFreq, link.mcWrData[MODE_DDR_BIT]); // RQ8
                synthEnable <= link.mcWrData[MODE_SYNTH_ON_BIT]; // RQ10
                ddrMode <= link.mcWrData[MODE_DDR_BIT]; // RQ11
            end
        end
    end

    // Read answer one cycle after the strobe; writes are acknowledged too
    always_ff @(posedge clk) begin
        if (reset) begin
            link.mcAck <= 1'b0;
            link.mcRdData <= READ_ZERO;
        end else begin
            link.mcAck <= link.mcWr || link.mcRd;
            link.mcRdData <= link.mcRd ? readMux : READ_ZERO;
        end
    end

    // Image for the store trails the registers by one cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            nvImageOut <= {RESET_MODE, RESET_FREQ3, RESET_FREQ2, RESET_FREQ1, RESET_FREQ0};
        end else begin
            nvImageOut <= {modeReg, pendingFreq}; // RQ16
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Crossing into the converter clock domain

    // Reset and mode are slow levels, so two flops each are enough
    dacfg_sync #(.W(2)) linkSyncer (
        .clk(linkClk),
        .d({reset, ddrMode}),
        .q({linkReset, linkDdr})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sample forwarding

    // Phase 0 edge launches the first half, phase 1 edge the second half.
    // Simple mode: the clock runs at twice the rate, so every other input is skipped.
    always_ff @(posedge linkClk) begin
        if (linkReset) begin
            phase <= 1'b0;
            link.sampleBusA <= MIDSCALE; // RQ1
            link.sampleBusB <= MIDSCALE;
            evenI <= MIDSCALE;
            evenQ <= MIDSCALE;
            holdQa <= MIDSCALE;
            holdQb <= MIDSCALE;
        end else begin
            phase <= ~phase;
            if (!phase) begin
                if (linkDdr) begin
                    // In-phase of the even and odd samples on this half
                    link.sampleBusA <= toOffset(evenI); // RQ19
                    link.sampleBusB <= toOffset(iSample); // RQ3
                    holdQa <= toOffset(evenQ);
                    holdQb <= toOffset(qSample);
                end else begin
                    link.sampleBusA <= toOffset(iSample); // RQ2
                    link.sampleBusB <= toOffset(qSample); // RQ1
                end
            end else begin
                if (linkDdr) begin
                    // Quadrature of the same pair on the other half
                    link.sampleBusA <= holdQa; // RQ19
                    link.sampleBusB <= holdQb;
                end
                evenI <= iSample;
                evenQ <= qSample;
            end
        end
    end

    // Clock toggles on the falling edge so each edge sits mid-word
    always_ff @(negedge linkClk) begin
        if (linkReset) begin
            link.sampleClk <= 1'b0;
        end else begin
            link.sampleClk <= phase; // RQ5
        end
    end

endmodule // dacfg_device

/* dacfg_host.sv */
// Receiving end: issues register reads and writes, and recovers sample pairs from the
// forwarded clock. Assumes the same system clock as the device's register side.
`timescale 1ns/1ps

module dacfg_host (
    // System clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register command port
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire dacfg_pkg::dacfg_addr_t cmdAddr,
    input wire dacfg_pkg::dacfg_byte_t cmdData,
    output logic cmdReady,
    output logic doneValid,
    output dacfg_pkg::dacfg_byte_t rdData,
    // Link to the device
    dacfg_link_if.host link,
    // Recovered samples, sampleClk domain
    output dacfg_pkg::dacfg_word_t rxIEven,
    output dacfg_pkg::dacfg_word_t rxQEven,
    output dacfg_pkg::dacfg_word_t rxIOdd,
    output dacfg_pkg::dacfg_word_t rxQOdd,
    output logic rxValid,
    output logic rxDdr
);
    import dacfg_pkg::*;

    typedef enum logic {HOST_IDLE, HOST_WAIT} dacfg_host_e;

    dacfg_host_e state;
    dacfg_byte_t shadow [4];
    logic hostDdr;
    logic pendRead;
    logic rxReset;
    logic rxHold;
    logic rxSeen;
    logic primed;
    dacfg_word_t posA;
    dacfg_word_t posB;
    dacfg_word_t negA;
    dacfg_word_t negB;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode

    wire cmdTake = cmdValid && (state == HOST_IDLE);
    wire dacfg_freq_t shadowFreq = {shadow[3], shadow[2], shadow[1], shadow[0]};
    wire modeCmd = cmdWrite && (cmdAddr == ADDR_MODE);
    // Force DDR on when the staged rate is beyond simple mode
    wire dacfg_byte_t outData = (modeCmd && (shadowFreq > SIMPLE_MAX_HZ)) ?
        (cmdData | MODE_DDR_MASK) : cmdData; // RQ12

    ////////////////////////////////////////////////////////////////////////////
    // Register link sequencer

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= HOST_IDLE;
            cmdReady <= 1'b1;
            doneValid <= 1'b0;
            rdData <= READ_ZERO;
            link.mcWr <= 1'b0;
            link.mcRd <= 1'b0;
            link.mcAddr <= ADDR_FREQ0;
            link.mcWrData <= READ_ZERO;
            pendRead <= 1'b0;
            hostDdr <= 1'b0;
            shadow[0] <= RESET_FREQ0;
            shadow[1] <= RESET_FREQ1;
            shadow[2] <= RESET_FREQ2;
            shadow[3] <= RESET_FREQ3;
        end else begin
            doneValid <= 1'b0;
            link.mcWr <= 1'b0;
            link.mcRd <= 1'b0;
            case (state)
                HOST_IDLE: begin
                    if (cmdTake) begin
                        link.mcWr <= cmdWrite;
                        link.mcRd <= !cmdWrite;
                        link.mcAddr <= cmdAddr;
                        link.mcWrData <= outData;
                        pendRead <= !cmdWrite;
                        cmdReady <= 1'b0;
                        state <= HOST_WAIT;
                        if (cmdWrite && cmdAddr <= ADDR_FREQ3) begin
                            shadow[cmdAddr[1:0]] <= cmdData;
                        end
                        if (modeCmd) begin
                            hostDdr <= outData[MODE_DDR_BIT];
                        end
                    end
                end
                HOST_WAIT: begin
                    if (link.mcAck) begin
                        doneValid <= 1'b1;
                        rdData <= link.mcRdData;
                        cmdReady <= 1'b1;
                        state <= HOST_IDLE;
                        // A mode read also teaches the receiver the restored format
                        if (pendRead && link.mcAddr == ADDR_MODE) begin
                            hostDdr <= link.mcRdData[MODE_DDR_BIT];
                        end
                    end
                end
                default: begin
                    state <= HOST_IDLE;
                    cmdReady <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample capture on the forwarded clock

    // Forwarded clock is dead during reset, so hold capture reset until its echo returns
    always_ff @(posedge clk) begin
        if (reset) begin
            rxHold <= 1'b1;
        end else if (rxSeen) begin
            rxHold <= 1'b0;
        end
    end

    dacfg_sync #(.W(1)) rxEcho (
        .clk(clk),
        .d(rxReset),
        .q(rxSeen)
    );

    dacfg_sync #(.W(2)) rxSyncer (
        .clk(link.sampleClk),
        .d({rxHold, hostDdr}),
        .q({rxReset, rxDdr})
    );

    // Falling edge holds the quadrature half in DDR
    always_ff @(negedge link.sampleClk) begin
        if (rxReset) begin
            negA <= MIDSCALE;
            negB <= MIDSCALE;
        end else begin
            negA <= link.sampleBusA; // RQ18
            negB <= link.sampleBusB;
        end
    end

    // Rising edge takes the in-phase half, then pairs it with the last falling half
    always_ff @(posedge link.sampleClk) begin
        if (rxReset) begin
            posA <= MIDSCALE;
            posB <= MIDSCALE;
            primed <= 1'b0;
            rxValid <= 1'b0;
            rxIEven <= MIDSCALE;
            rxQEven <= MIDSCALE;
            rxIOdd <= MIDSCALE;
            rxQOdd <= MIDSCALE;
        end else begin
            posA <= link.sampleBusA; // RQ4
            posB <= link.sampleBusB;
            primed <= 1'b1;
            if (rxDdr) begin
                rxIEven <= posA; // RQ19
                rxQEven <= negA;
                rxIOdd <= posB;
                rxQOdd <= negB;
                rxValid <= primed;
            end else begin
                rxIEven <= link.sampleBusA; // RQ2
                rxQEven <= link.sampleBusB;
                rxIOdd <= MIDSCALE;
                rxQOdd <= MIDSCALE;
                rxValid <= 1'b1;
            end
        end
    end

endmodule // dacfg_host

/* dacfg_link_if.sv */
// Link between converter device and receiving logic: forwarded clock, two sample buses,
// and the monitor-and-control register port on the shared system clock.
// Assumes the bench joins both ends through this interface.
`timescale 1ns/1ps

interface dacfg_link_if;
    import dacfg_pkg::*;

    // Sample side
    logic sampleClk;
    dacfg_word_t sampleBusA;
    dacfg_word_t sampleBusB;
    // Register side
    dacfg_addr_t mcAddr;
    dacfg_byte_t mcWrData;
    logic mcWr;
    logic mcRd;
    dacfg_byte_t mcRdData;
    logic mcAck;

    modport device (
        output sampleClk,
        output sampleBusA,
        output sampleBusB,
        input mcAddr,
        input mcWrData,
        input mcWr,
        input mcRd,
        output mcRdData,
        output mcAck
    );

    modport host (
        input sampleClk,
        input sampleBusA,
        input sampleBusB,
        output mcAddr,
        output mcWrData,
        output mcWr,
        output mcRd,
        input mcRdData,
        input mcAck
    );

endinterface

/* dacfg_pkg.sv */
// Shared constants, types and helpers for the dual converter sample output and config link.
// Assumes one system clock for the register link and a separate converter clock at the sample side.
//
// Operation
// [RQ1] Samples are 10-bit offset, midscale means zero
// [RQ2] Simple mode: bus A in-phase, bus B quadrature
// [RQ3] DDR mode interlaces in-phase and quadrature words
// [RQ4] Receiver captures on forwarded clock rising edge
// [RQ5] Forwarded clock follows selected converter clock source
// [RQ6] External clock: fs in DDR, 2fs otherwise
// [RQ7] Frequency in hertz over four bytes, LSB first
// [RQ8] Frequency steps: 0.5 MHz simple, 1 MHz DDR
// [RQ9] New frequency applied only on mode register write
// [RQ10] Mode bit 0 switches internal clock generator
// [RQ11] Mode bit 1 selects simple or DDR output
// [RQ12] Software enables DDR above simple-mode rate limit
// [RQ13] Undefined registers and bits accepted, no effect
// [RQ14] Control registers are 8-bit, read and write
// [RQ15] Status bit 0 reports synthesizer lock
// [RQ16] Configuration kept in non-volatile storage
// [RQ17] Software checks lock after frequency change
// [RQ18] DDR receiver captures on both clock edges
// [RQ19] DDR: bus A even samples, bus B odd
// [RQ20] Frequency bytes pending until update write

package dacfg_pkg;

    typedef logic [9:0] dacfg_word_t;
    typedef logic [7:0] dacfg_byte_t;
    typedef logic [2:0] dacfg_addr_t;
    typedef logic [31:0] dacfg_freq_t;
    typedef logic [39:0] dacfg_nv_t;

    ////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam dacfg_addr_t ADDR_FREQ0 = 3'h0;
    localparam dacfg_addr_t ADDR_FREQ3 = 3'h3;
    localparam dacfg_addr_t ADDR_MODE = 3'h4;
    localparam dacfg_addr_t ADDR_STATUS = 3'h5;

    // Mode and status register fields
    localparam int MODE_SYNTH_ON_BIT = 0;
    localparam int MODE_DDR_BIT = 1;
    localparam int STATUS_LOCK_BIT = 0;
    localparam dacfg_byte_t MODE_DDR_MASK = 8'h02;

    // Reset configuration: 40 Msamples/s, internal generator on
    localparam dacfg_byte_t RESET_FREQ0 = 8'h00;
    localparam dacfg_byte_t RESET_FREQ1 = 8'h5A;
    localparam dacfg_byte_t RESET_FREQ2 = 8'h62;
    localparam dacfg_byte_t RESET_FREQ3 = 8'h02;
    localparam dacfg_byte_t RESET_MODE = 8'h01;
    localparam dacfg_byte_t READ_ZERO = 8'h00;

    // Frequency steps and simple-mode upper limit, in hertz
    localparam dacfg_freq_t STEP_SIMPLE_HZ = 32'h0007_A120;
    localparam dacfg_freq_t STEP_DDR_HZ = 32'h000F_4240;
    localparam dacfg_freq_t SIMPLE_MAX_HZ = 32'h0642_2C40;

    // Sample coding
    localparam dacfg_word_t MIDSCALE = 10'h200;

    ////////////////////////////////////////////////////////////////////////////
    // Two's complement to offset binary: flip the sign bit
    function automatic dacfg_word_t toOffset(input dacfg_word_t s);
        return s ^ MIDSCALE;
    endfunction

    // Round the programmed rate down to the step of the chosen mode
    function automatic dacfg_freq_t quantize(input dacfg_freq_t f, input logic ddr);
        dacfg_freq_t step;
        step = ddr ? STEP_DDR_HZ : STEP_SIMPLE_HZ;
        return f - (f % step);
    endfunction

endpackage

/* dacfg_sync.sv */
// Two-flop level synchroniser, W bits wide.
// Assumes each bit is a slow level; multi-bit values must not change together.
`timescale 1ns/1ps

module dacfg_sync #(
    parameter int W = 1
) (
    // Destination clock
    input wire logic clk,
    // Level from another domain
    input wire logic [W-1:0] d,
    // Synchronised level
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
        meta <= d;
        q <= meta;
    end

endmodule // dacfg_sync

/* dacfg_tb.sv */
// Bench joining the converter device and the receiving end through the link interface.
// Assumes the package, interface, design modules and checker are compiled first.
`timescale 1ns/1ps

module dacfg_tb;
    import dacfg_pkg::*;

    localparam dacfg_nv_t NV_CFG = 40'h01_0393_8700;
    localparam dacfg_word_t I_EVEN = 10'h3FF;
    localparam dacfg_word_t I_ODD = 10'h200;
    localparam dacfg_word_t Q_EVEN = 10'h1FF;
    localparam dacfg_word_t Q_ODD = 10'h001;
    logic clk, reset, linkClk, synthLocked, cmdValid, cmdWrite, cmdReady, doneValid;
    logic rxValid, rxDdr, synthLoad, synthEnable, ddrMode;
    dacfg_addr_t cmdAddr;
    dacfg_byte_t cmdData, rdData, got;
    dacfg_word_t iSample, qSample, rxIEven, rxQEven, rxIOdd, rxQOdd;
    dacfg_freq_t synthFreqHz, f;
    dacfg_nv_t nvOut;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int loads = 0;

    dacfg_link_if link ();
    dacfg_device u_dacfg_device (.clk(clk), .reset(reset), .linkClk(linkClk), .iSample(iSample),
        .qSample(qSample), .synthLocked(synthLocked), .nvImage(NV_CFG), .link(link), .synthFreqHz(synthFreqHz),
        .synthLoad(synthLoad), .synthEnable(synthEnable), .ddrMode(ddrMode), .nvImageOut(nvOut));
    dacfg_host u_dacfg_host (.clk(clk), .reset(reset), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
        .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady), .doneValid(doneValid), .rdData(rdData),
        .link(link), .rxIEven(rxIEven), .rxQEven(rxQEven), .rxIOdd(rxIOdd), .rxQOdd(rxQOdd),
        .rxValid(rxValid), .rxDdr(rxDdr));
    dacfg_chk u_dacfg_chk (.clk(clk), .reset(reset), .linkClk(linkClk), .sampleClk(link.sampleClk),
        .mcAddr(link.mcAddr), .mcWr(link.mcWr), .mcRd(link.mcRd), .mcRdData(link.mcRdData), .mcAck(link.mcAck));

    ////////////////////////////////////////
    // Clocks, unrelated in phase
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        linkClk = 1'b0;
        #3.1;
        forever #24 linkClk = ~linkClk;
    end

    // Even samples are the ones launched while the forwarded clock is high
    always @(negedge linkClk) begin
        #1;
        iSample = link.sampleClk ? I_EVEN : I_ODD;
        qSample = link.sampleClk ? Q_EVEN : Q_ODD;
    end

    // Hang guard, far above the expected run length; also counts apply pulses
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (synthLoad === 1'b1) begin
            loads <= loads + 1;
        end
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            close_out();
        end
    end

    ////////////////////////////////////////
    // Compares
    task automatic chk_byte(input string what, input dacfg_byte_t exp, input dacfg_byte_t seen);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic chk_word(input string what, input dacfg_word_t exp, input dacfg_word_t seen);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic chk_freq(input string what, input dacfg_freq_t exp, input dacfg_freq_t seen);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One register access through the host; read data lands in got
    task automatic cmd(input logic wr, input dacfg_addr_t a, input dacfg_byte_t d);
        while (cmdReady !== 1'b1) @(negedge clk);
        cmdValid = 1'b1;
        cmdWrite = wr;
        cmdAddr = a;
        cmdData = d;
        @(negedge clk);
        cmdValid = 1'b0;
        while (doneValid !== 1'b1) @(negedge clk);
        got = rdData;
    endtask

    // Recovered samples, read mid-cycle of the forwarded clock
    task automatic chk_rx(input logic ddr, input dacfg_word_t ie, qe, io, qo);
        repeat (40) @(negedge link.sampleClk);
        chk_byte("rx mode", {7'h00, ddr}, {7'h00, rxDdr});
        chk_byte("rx valid", 8'h01, {7'h00, rxValid});
        chk_word("i even", ie, rxIEven);
        chk_word("q even", qe, rxQEven);
        chk_word("i odd", io, rxIOdd);
        chk_word("q odd", qo, rxQOdd);
        @(negedge clk);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    // Main sequence
    initial begin
        reset = 1'b1;
        cmdValid = 1'b0;
        cmdWrite = 1'b0;
        cmdAddr = 3'h0;
        cmdData = 8'h00;
        synthLocked = 1'b1;
        iSample = I_ODD;
        qSample = Q_ODD;
        f = 32'h039E_F8B0;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        for (int k = 0; k < 5; k++) begin
            cmd(1'b0, k[2:0], 8'h00);
            chk_byte("stored byte", NV_CFG[8*k +: 8], got);
        end
        chk_freq("reset rate", 32'h0393_8700, synthFreqHz);
        for (int k = 0; k < 4; k++) begin
            cmd(1'b1, k[2:0], f[8*k +: 8]);
        end
        chk_freq("rate held", 32'h0393_8700, synthFreqHz);
        chk_freq("early loads", 32'h0000_0001, loads);
        for (int k = 0; k < 4; k++) begin
            cmd(1'b0, k[2:0], 8'h00);
            chk_byte("rate byte", f[8*k +: 8], got);
        end
        cmd(1'b1, ADDR_MODE, 8'h01);
        chk_freq("simple rate", f - f % STEP_SIMPLE_HZ, synthFreqHz);
        chk_byte("ddr off", 8'h00, {7'h00, ddrMode});
        chk_byte("synth on", 8'h01, {7'h00, synthEnable});
        chk_rx(1'b0, 10'h000, 10'h201, 10'h200, 10'h200);
        cmd(1'b1, ADDR_MODE, 8'h02);
        chk_freq("ddr rate", f - f % STEP_DDR_HZ, synthFreqHz);
        chk_byte("ddr on", 8'h01, {7'h00, ddrMode});
        chk_byte("synth off", 8'h00, {7'h00, synthEnable});
        chk_rx(1'b1, 10'h1FF, 10'h3FF, 10'h000, 10'h201);
        // Writes to places that hold nothing
        cmd(1'b1, ADDR_STATUS, 8'hFE);
        cmd(1'b1, 3'h6, 8'hFF);
        cmd(1'b0, 3'h6, 8'h00);
        chk_byte("unmapped read", 8'h00, got);
        synthLocked = 1'b0;
        repeat (4) @(negedge clk);
        cmd(1'b0, ADDR_STATUS, 8'h00);
        chk_byte("lock low", 8'h00, got);
        synthLocked = 1'b1;
        repeat (4) @(negedge clk);
        cmd(1'b0, ADDR_STATUS, 8'h00);
        chk_byte("lock high", 8'h01, got);
        // Spare mode bits stored but inert
        cmd(1'b1, ADDR_MODE, 8'hF1);
        cmd(1'b0, ADDR_MODE, 8'h00);
        chk_byte("mode read", 8'hF1, got);
        chk_byte("spare ddr", 8'h00, {7'h00, ddrMode});
        chk_freq("spare rate", f - f % STEP_SIMPLE_HZ, synthFreqHz);
        chk_byte("stored mode", 8'hF1, nvOut[39:32]);
        chk_freq("stored rate", f, nvOut[31:0]);
        // Rate above the simple-mode limit forces DDR on
        f = 32'h08F0_D180;
        for (int k = 0; k < 4; k++) begin
            cmd(1'b1, k[2:0], f[8*k +: 8]);
        end
        cmd(1'b1, ADDR_MODE, 8'h01);
        chk_byte("forced ddr", 8'h01, {7'h00, ddrMode});
        chk_freq("forced rate", f - f % STEP_DDR_HZ, synthFreqHz);
        chk_freq("load count", 32'h0000_0005, loads);
        close_out();
    end

endmodule // dacfg_tb
